// File: design/msdc_regs.vh
`ifndef MSDC_REGS_VH
`define MSDC_REGS_VH

// Register indices on the two-bit digit address
`define MSDC_ADDR_DIGIT_ONE    2'h0
`define MSDC_ADDR_DIGIT_TWO    2'h1
`define MSDC_ADDR_DIGIT_THREE  2'h2
`define MSDC_ADDR_DIGIT_FOUR   2'h3

// Segment pattern layout
`define MSDC_SEG_WIDTH         8
`define MSDC_DP_BIT            7
`define MSDC_SEG_RESET         8'h00

// Scan timing
`define MSDC_CLK_PERIOD_NS     8
`define MSDC_STEP_TIME_NS      476000
`define MSDC_STEP_CYCLES       (`MSDC_STEP_TIME_NS / `MSDC_CLK_PERIOD_NS)
`define MSDC_BLANK_TIME_NS     10000
`define MSDC_BLANK_CYCLES      \
  ((`MSDC_BLANK_TIME_NS + `MSDC_CLK_PERIOD_NS - 1) / `MSDC_CLK_PERIOD_NS)

`endif

// File: design/msdc_scan.v
`timescale 1ns/1ns
`include "msdc_regs.vh"

module msdc_scan #(
  parameter [31:0] STEP_CYCLES  = `MSDC_STEP_CYCLES,
  parameter [31:0] BLANK_CYCLES = `MSDC_BLANK_CYCLES
) (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       srst_in,
  // Control
  input  wire       run_in,
  // Scan position
  output reg  [1:0] digit_out,
  output reg        blank_out
);

  reg [31:0] cnt;

  always @(posedge mclk_in) begin
    if (srst_in) begin
      cnt       <= 32'h0;
      digit_out <= 2'h0;
      blank_out <= 1'b1;
    end else if (run_in) begin
      if (cnt == STEP_CYCLES - 32'h1) begin
        cnt       <= 32'h0;
        digit_out <= digit_out + 2'h1;
        blank_out <= 1'b1;
      end else begin
        cnt <= cnt + 32'h1;
        if (cnt == BLANK_CYCLES - 32'h1) begin
          blank_out <= 1'b0;
        end
      end
    end else begin
      cnt       <= 32'h0;
      blank_out <= 1'b1;
    end
  end

endmodule // msdc_scan

// File: design/msdc_seg_reg.v
`timescale 1ns/1ns
`include "msdc_regs.vh"

module msdc_seg_reg (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       srst_in,
  // Write path
  input  wire       sel_in,
  input  wire [7:0] data_in,
  // Stored pattern
  output reg  [7:0] seg_out
);

  always @(posedge mclk_in) begin
    if (srst_in) begin
      seg_out <= `MSDC_SEG_RESET;
    end else if (sel_in) begin
      seg_out <= data_in;
    end
  end

endmodule // msdc_seg_reg

// File: design/msdc_top.v
// How it works
// - Four separate 8-bit patterns, one per digit, every segment independent.
// - Eight data inputs including decimal point form the written digit byte.
// - Two-bit address 00..11 selects digit one through four.
// - Writes pass only while chip select and write strobe are both low.
// - Value held from the rising edge of select or strobe onward.
// - Internal free-running timer steps through stored patterns onto segments.
// - Direction low: digit lines pulsed one at a time, only shown one high.
// - Segments driven while enable low, released to high impedance when high.
// - Segment enable high does not stop the digit scan.
// - Direction high: digit lines become inputs and the scan stops.
// - Externally raised digit line selects that digit's pattern for output.
// - Follower devices track a master's digit lines for cascading.
// - Enable and direction high with all lines low: standby, nothing driven.
`timescale 1ns/1ns
`include "msdc_regs.vh"

module msdc_top #(
  parameter [31:0] STEP_CYCLES = `MSDC_STEP_CYCLES
) (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       srst_in,
  // Processor write port
  input  wire       chip_sel_n_in,
  input  wire       write_n_in,
  input  wire       digit_addr_low_in,
  input  wire       digit_addr_high_in,
  input  wire [7:0] seg_data_in,
  // Output control
  input  wire       segment_drive_enable_n_in,
  input  wire       digit_direction_ctl_in,
  // Segment pins
  output reg  [7:0] seg_out,
  output reg  [7:0] seg_oe_out,
  // Digit pins, two-way
  input  wire [3:0] digit_line_in,
  output reg  [3:0] digit_line_out,
  output reg  [3:0] digit_line_oe_out,
  // Status
  output reg        standby_out
);

  wire [1:0] addr;
  wire       wr_open;
  wire [3:0] wr_sel;
  wire [7:0] pat0;
  wire [7:0] pat1;
  wire [7:0] pat2;
  wire [7:0] pat3;
  wire [1:0] scan_digit;
  wire       scan_blank;
  wire       scan_run;
  wire       standby;
  reg  [7:0] shown;
  reg        shown_valid;

  assign addr    = {digit_addr_high_in, digit_addr_low_in};
  assign wr_open = ~chip_sel_n_in & ~write_n_in;

  // Register follows data while open, holds once select or strobe rises
  assign wr_sel[0] = wr_open & (addr == `MSDC_ADDR_DIGIT_ONE);
  assign wr_sel[1] = wr_open & (addr == `MSDC_ADDR_DIGIT_TWO);
  assign wr_sel[2] = wr_open & (addr == `MSDC_ADDR_DIGIT_THREE);
  assign wr_sel[3] = wr_open & (addr == `MSDC_ADDR_DIGIT_FOUR);

  msdc_seg_reg u_reg0 (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .sel_in  (wr_sel[0]),
    .data_in (seg_data_in),
    .seg_out (pat0)
  );
  msdc_seg_reg u_reg1 (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .sel_in  (wr_sel[1]),
    .data_in (seg_data_in),
    .seg_out (pat1)
  );
  msdc_seg_reg u_reg2 (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .sel_in  (wr_sel[2]),
    .data_in (seg_data_in),
    .seg_out (pat2)
  );
  msdc_seg_reg u_reg3 (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .sel_in  (wr_sel[3]),
    .data_in (seg_data_in),
    .seg_out (pat3)
  );

  assign standby  = segment_drive_enable_n_in & digit_direction_ctl_in &
                    (digit_line_in == 4'h0);
  assign scan_run = ~digit_direction_ctl_in;

  msdc_scan #(
    .STEP_CYCLES  (STEP_CYCLES),
    .BLANK_CYCLES (`MSDC_BLANK_CYCLES)
  ) u_scan (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .run_in    (scan_run),
    .digit_out (scan_digit),
    .blank_out (scan_blank)
  );

  // Choose the pattern to show
  always @* begin
    shown       = 8'h00;
    shown_valid = 1'b0;
    if (!digit_direction_ctl_in) begin
      shown_valid = 1'b1;
      case (scan_digit)
        2'h0: shown = pat0;
        2'h1: shown = pat1;
        2'h2: shown = pat2;
        2'h3: shown = pat3;
        default: shown = 8'h00;
      endcase
    end else begin
      shown_valid = 1'b1;
      case (digit_line_in)
        4'h1: shown = pat0;
        4'h2: shown = pat1;
        4'h4: shown = pat2;
        4'h8: shown = pat3;
        default: shown_valid = 1'b0;
      endcase
    end
  end

  // Output pins
  always @(posedge mclk_in) begin
    if (srst_in) begin
      seg_out           <= 8'h00;
      seg_oe_out        <= 8'h00;
      digit_line_out    <= 4'h0;
      digit_line_oe_out <= 4'h0;
      standby_out       <= 1'b0;
    end else begin
      standby_out <= standby;
      seg_out     <= shown_valid ? shown : 8'h00;
      if (segment_drive_enable_n_in) begin
        seg_oe_out <= 8'h00;
      end else begin
        seg_oe_out <= 8'hFF;
      end
      if (digit_direction_ctl_in) begin
        digit_line_out    <= 4'h0;
        digit_line_oe_out <= 4'h0;
      end else begin
        digit_line_oe_out <= 4'hF;
        digit_line_out    <= scan_blank ? 4'h0 :
                             (4'h1 << scan_digit);
      end
    end
  end

endmodule // msdc_top

// File: tb/msdc_chk.sv
`timescale 1ns/1ns
module msdc_chk #(parameter [31:0] STEP_CYCLES = 32'h514) (
  input wire       mclk_in,
  input wire       srst_in,
  input wire       segment_drive_enable_n_in,
  input wire       digit_direction_ctl_in,
  input wire [3:0] digit_line_in,
  input wire [7:0] seg_out,
  input wire [7:0] seg_oe_out,
  input wire [3:0] digit_line_out,
  input wire [3:0] digit_line_oe_out,
  input wire       standby_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic [31:0] dark_cnt;
  logic [3:0]  last_lit;
  // Count dark scan cycles and remember the last lit digit line
  always @(posedge mclk_in) begin
    if (srst_in || digit_direction_ctl_in) begin
      dark_cnt <= 32'h0;
      last_lit <= 4'h0;
    end else begin
      dark_cnt <= (digit_line_out == 4'h0) ? dark_cnt + 32'h1 : 32'h0;
      if (digit_line_out != 4'h0) last_lit <= digit_line_out;
    end
  end
  sequence s_next_lit;
    $rose(|digit_line_out) && last_lit != 4'h0;
  endsequence
  a_seg_on: assert property (
    !segment_drive_enable_n_in |=> seg_oe_out == 8'hFF) else $error("oe");
  a_seg_off: assert property (
    segment_drive_enable_n_in |=> seg_oe_out == 8'h00) else $error("oe");
  a_dig_drive: assert property (
    !digit_direction_ctl_in |=> digit_line_oe_out == 4'hF) else $error("d");
  a_dig_input: assert property (
    digit_direction_ctl_in |=> digit_line_oe_out == 4'h0) else $error("d");
  a_one_hot: assert property (
    |digit_line_oe_out |-> $onehot0(digit_line_out)) else $error("hot");
  a_standby_on: assert property (
    segment_drive_enable_n_in && digit_direction_ctl_in &&
    digit_line_in == 4'h0 |=> standby_out) else $error("sb");
  a_follow_none: assert property (
    digit_direction_ctl_in && digit_line_in == 4'h0 |=> seg_out == 8'h00)
    else $error("none");
  a_scan_order: assert property (
    disable iff (srst_in || digit_direction_ctl_in)
    s_next_lit |-> digit_line_out == {last_lit[2:0], last_lit[3]})
    else $error("ord");
  a_scan_alive: assert property (
    dark_cnt < STEP_CYCLES) else $error("scan");
endmodule // msdc_chk

// File: tb/msdc_master.sv
`timescale 1ns/1ns
module msdc_master (
  input  wire       en_in,
  input  wire [1:0] sel_in,
  output wire [3:0] line_out
);
  // One digit line high while following, all low when idle
  assign line_out = en_in ? 4'h1 << sel_in : 4'h0;
endmodule // msdc_master

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       clk = 0, rst = 1, cs_n = 1, we_n = 1, en_n = 0, dir = 0;
  logic       fol = 0, stby;
  logic [1:0] addr = 0, sel = 0;
  logic [7:0] din = 0, so, segment_drive_enable_n;
  logic [3:0] dl_in, dl_out, dl_oe, ext;
  logic [7:0] pat [4] = '{8'h3F, 8'h06, 8'h5B, 8'hCF};
  int         bad_count = 0, n_checks = 0, k;
  assign dl_in = (dl_oe & dl_out) | (~dl_oe & ext);
  msdc_master msdc_master_i (.en_in(fol), .sel_in(sel), .line_out(ext));
  msdc_top #(.STEP_CYCLES(1300)) msdc_top_i (.mclk_in(clk), .srst_in(rst),
    .chip_sel_n_in(cs_n), .write_n_in(we_n), .digit_addr_low_in(addr[0]),
    .digit_addr_high_in(addr[1]), .seg_data_in(din),
    .segment_drive_enable_n_in(en_n), .digit_direction_ctl_in(dir),
    .seg_out(so), .seg_oe_out(segment_drive_enable_n), .digit_line_in(dl_in),
    .digit_line_out(dl_out), .digit_line_oe_out(dl_oe), .standby_out(stby));
  initial forever #4 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d, input logic c);
    @(negedge clk);
    cs_n = c;
    we_n = 0;
    addr = a;
    din = d;
    @(negedge clk);
    cs_n = 1;
    we_n = 1;
    din = ~d;
    addr = ~a;
  endtask
  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (k = 0; k < 4; k++) wr(k, pat[k], 0);
    wr(0, 8'hAA, 1);
    dir = 1;
    fol = 1;
    for (k = 0; k < 4; k++) begin
      sel = k;
      repeat (3) @(negedge clk);
      chk(so, pat[k]);
    end
    fol = 0;
    repeat (3) @(negedge clk);
    chk(so, 8'h00);
    en_n = 1;
    repeat (3) @(negedge clk);
    chk(stby, 8'h01);
    chk(segment_drive_enable_n, 8'h00);
    dir = 0;
    for (k = 0; k < 5; k++) begin
      en_n = (k == 2);
      repeat (1400) if (dl_out == 0) @(negedge clk);
      repeat (5) @(negedge clk);
      chk(dl_out, 8'h01 << (k % 4));
      chk(segment_drive_enable_n, (k == 2) ? 8'h00 : 8'hFF);
      if (k != 2) chk(so, pat[k % 4]);
      repeat (60) if (dl_out != 0) @(negedge clk);
    end
    tally_and_finish;
  end
endmodule // tb_top
bind msdc_top msdc_chk #(.STEP_CYCLES(STEP_CYCLES)) msdc_chk_i (
  .mclk_in(mclk_in), .srst_in(srst_in),
  .segment_drive_enable_n_in(segment_drive_enable_n_in),
  .digit_direction_ctl_in(digit_direction_ctl_in),
  .digit_line_in(digit_line_in), .seg_out(seg_out), .seg_oe_out(seg_oe_out),
  .digit_line_out(digit_line_out), .digit_line_oe_out(digit_line_oe_out),
  .standby_out(standby_out));
